// *** rtl/sbspm_regs.svh ***
`ifndef SBSPM_REGS_SVH
`define SBSPM_REGS_SVH

// ****************************************************************
// Clock rate
// ****************************************************************
`define SBSPM_CLK_PERIOD_NS 50

// ****************************************************************
// Timing figures and their cycle counts (rounded up)
// ****************************************************************
`define SBSPM_ROW_CYCLE_NS 67
`define SBSPM_ROW_CYCLE_CYC \
  ((`SBSPM_ROW_CYCLE_NS + `SBSPM_CLK_PERIOD_NS - 1) / `SBSPM_CLK_PERIOD_NS)
`define SBSPM_PRECHARGE_NS 19
`define SBSPM_PRECHARGE_CYC \
  ((`SBSPM_PRECHARGE_NS + `SBSPM_CLK_PERIOD_NS - 1) / `SBSPM_CLK_PERIOD_NS)
`define SBSPM_SELF_REFRESH_EXIT_CYC 1
`define SBSPM_REFRESH_PERIOD_MS 64
`define SBSPM_REFRESH_ROWS 8192
`define SBSPM_INIT_PAUSE_US 200
`define SBSPM_INIT_PAUSE_CYC \
  ((`SBSPM_INIT_PAUSE_US * 1000 + `SBSPM_CLK_PERIOD_NS - 1) / \
   `SBSPM_CLK_PERIOD_NS)

// ****************************************************************
// Widths
// ****************************************************************
`define SBSPM_BANKS 4
`define SBSPM_TOP_CNT_W 12
`define SBSPM_BANK_CNT_W 4

`endif

// *** rtl/sbspm_pkg.sv ***
package sbspm_pkg;

  // ****************************************************************
  // Command bus as sampled on the clock edge
  // ****************************************************************
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic a10;
    logic [1:0] ba;
  } sbspm_pins_t;

  typedef enum logic [3:0] {
    CMD_DESEL = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACT = 4'h2,
    CMD_RD = 4'h3,
    CMD_WR = 4'h4,
    CMD_PRE = 4'h5,
    CMD_BST = 4'h6,
    CMD_REF = 4'h7,
    CMD_MRS = 4'h8
  } sbspm_cmd_t;

  // ****************************************************************
  // Bank and device states, Gray along the usual path
  // ****************************************************************
  typedef enum logic [3:0] {
    BANK_IDLE = 4'h0,
    BANK_ACTIVATING = 4'h1,
    BANK_ROW_ACTIVE = 4'h3,
    BANK_READ = 4'h2,
    BANK_WRITE = 4'h6,
    BANK_READ_AP = 4'h7,
    BANK_WRITE_AP = 4'h5,
    BANK_PRECHARGING = 4'h4
  } sbspm_bank_st_t;

  typedef enum logic [3:0] {
    PWR_NORMAL = 4'h0,
    PWR_PRE_PD = 4'h1,
    PWR_ACT_PD = 4'h3,
    PWR_SELF_REF = 4'h2,
    PWR_SREF_EXIT = 4'h6,
    PWR_DEEP_PD = 4'h7,
    PWR_INIT_WAIT = 4'h5,
    PWR_REFRESHING = 4'h4,
    PWR_MODE_REG = 4'hc
  } sbspm_pwr_t;

  // ****************************************************************
  // Per-bank request and state records, and the device-level register record
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic sel;
    sbspm_cmd_t cmd;
    logic ap;
    logic bst_hit;
    logic intr;
    logic flush;
  } sbspm_bank_req_t;

  typedef struct packed {
    sbspm_bank_st_t st;
    logic [3:0] cnt;
  } sbspm_bank_reg_t;

  typedef struct packed {
    sbspm_pins_t s1;
    sbspm_pins_t s2;
    logic cke_prev;
    sbspm_pwr_t pwr;
    logic [11:0] cnt;
    logic [1:0] last_bank;
    logic last_valid;
    logic taken;
    logic illegal;
    logic bufs_on;
  } sbspm_top_reg_t;

  // Command decode from chip select and the three strobes
  function automatic sbspm_cmd_t sbspm_decode(input sbspm_pins_t p);
    sbspm_cmd_t c;
    c = CMD_DESEL;
    if (!p.cs_n)
    begin
      case ({p.ras_n, p.cas_n, p.we_n})
        3'b111: c = CMD_NOP;
        3'b011: c = CMD_ACT;
        3'b101: c = CMD_RD;
        3'b100: c = CMD_WR;
        3'b010: c = CMD_PRE;
        3'b110: c = CMD_BST;
        3'b001: c = CMD_REF;
        default: c = CMD_MRS;
      endcase
    end
    return c;
  endfunction

endpackage

// *** rtl/sbspm_bank.sv ***
`timescale 1ns/1ps
`include "sbspm_regs.svh"

module sbspm_bank
  import sbspm_pkg::*;
#(
  parameter int unsigned RCD_CYC = 1,
  parameter int unsigned RP_CYC = `SBSPM_PRECHARGE_CYC,
  parameter int unsigned BURST_LEN = 4
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Decoded request for this bank
  input wire sbspm_bank_req_t req_i,
  // Bank state
  output sbspm_bank_st_t state_o
);

  sbspm_bank_reg_t q;
  sbspm_bank_reg_t next_q;
  logic hit;
  logic done;

  // Next state of one bank
  always_comb
  begin
    next_q = q;
    hit = req_i.valid && req_i.sel;
    done = (q.cnt == 4'h1);
    if (q.cnt != 4'h0)
    begin
      next_q.cnt = q.cnt - 4'h1;
    end
    case (q.st)
      BANK_IDLE:
      begin
        if (hit && req_i.cmd == CMD_ACT)
        begin
          next_q.st = BANK_ACTIVATING;
          next_q.cnt = 4'(RCD_CYC);
        end
        // precharge on idle is left as a no-op
      end
      BANK_ACTIVATING:
      begin
        // row active once the delay is met
        if (done)
        begin
          next_q.st = BANK_ROW_ACTIVE;
        end
      end
      BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE:
      begin
        // open-row decode, new burst or truncate
        if (hit && (req_i.cmd == CMD_RD || req_i.cmd == CMD_WR))
        begin
          if (req_i.ap)
          begin
            next_q.st = (req_i.cmd == CMD_RD) ? BANK_READ_AP : BANK_WRITE_AP;
            next_q.cnt = 4'(BURST_LEN + RP_CYC);
          end
          else
          begin
            next_q.st = (req_i.cmd == CMD_RD) ? BANK_READ : BANK_WRITE;
            next_q.cnt = 4'(BURST_LEN);
          end
        end
        else if (hit && req_i.cmd == CMD_PRE)
        begin
          next_q.st = BANK_PRECHARGING;
          next_q.cnt = 4'(RP_CYC);
        end
        // terminate only the most recent burst
        else if (q.st != BANK_ROW_ACTIVE && (done || (req_i.valid &&
                 req_i.cmd == CMD_BST && req_i.bst_hit)))
        begin
          next_q.st = BANK_ROW_ACTIVE;
          next_q.cnt = 4'h0;
        end
      end
      BANK_READ_AP, BANK_WRITE_AP:
      begin
        if (done)
        begin
          next_q.st = BANK_IDLE;
        end
        // Another bank's access cuts the burst, precharge begins now
        else if (req_i.valid && req_i.intr)
        begin
          next_q.st = BANK_PRECHARGING;
          next_q.cnt = 4'(RP_CYC);
        end
      end
      BANK_PRECHARGING:
      begin
        if (done)
        begin
          next_q.st = BANK_IDLE;
        end
      end
      default:
      begin
        next_q.st = BANK_IDLE;
        next_q.cnt = 4'h0;
      end
    endcase
    // Deep power-down loses every row
    if (req_i.flush)
    begin
      next_q.st = BANK_IDLE;
      next_q.cnt = 4'h0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '{st: BANK_IDLE, cnt: 4'h0};
    end
    else
    begin
      q <= next_q;
    end
  end

  assign state_o = q.st;

endmodule

// *** rtl/sbspm_top.sv ***
`timescale 1ns/1ps
`include "sbspm_regs.svh"

module sbspm_top
  import sbspm_pkg::*;
#(
  parameter int unsigned RCD_CYC = 1,
  parameter int unsigned MRD_CYC = 2,
  parameter int unsigned BURST_LEN = 4
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Command pins from the memory controller
  input wire sbspm_pins_t pins_i,
  // Bank and power state
  output wire sbspm_bank_st_t [3:0] bank_state_o,
  output sbspm_pwr_t pwr_mode_o,
  // Command outcome and buffer status
  output logic cmd_taken_o,
  output logic cmd_illegal_o,
  output logic bufs_on_o
);

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam int RC_CYC = `SBSPM_ROW_CYCLE_CYC;
  localparam int SREX_CYC = (RC_CYC > `SBSPM_SELF_REFRESH_EXIT_CYC) ?
                            RC_CYC : `SBSPM_SELF_REFRESH_EXIT_CYC;

  sbspm_top_reg_t q;
  sbspm_top_reg_t next_q;
  sbspm_bank_req_t [3:0] req;
  sbspm_bank_st_t [3:0] bst;
  sbspm_cmd_t cmd;
  logic cke_now;
  logic exec;
  logic go;
  logic all_idle;
  logic busy_access;
  logic done;

  // ****************************************************************
  // Bank summaries
  // ****************************************************************
  // Busy access means a burst or timed transition is under way
  always_comb
  begin
    all_idle = 1'b1;
    busy_access = 1'b0;
    for (int b = 0; b < `SBSPM_BANKS; b++)
    begin
      if (bst[b] != BANK_IDLE)
      begin
        all_idle = 1'b0;
      end
      if (bst[b] != BANK_IDLE && bst[b] != BANK_ROW_ACTIVE)
      begin
        busy_access = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Command and power control
  // ****************************************************************
  // Device-level next state; pins are read only after two flops
  always_comb
  begin
    next_q = q;
    // every pin sampled on the rising edge
    next_q.s1 = pins_i;
    next_q.s2 = q.s1;
    next_q.cke_prev = q.s2.cke;
    next_q.taken = 1'b0;
    next_q.illegal = 1'b0;
    cke_now = q.s2.cke;
    cmd = sbspm_decode(q.s2);
    done = (q.cnt == 12'h001);
    go = 1'b0;
    // decode only with enable high on both edges
    exec = (q.pwr == PWR_NORMAL) && q.cke_prev && cke_now;
    if (q.cnt != 12'h000)
    begin
      next_q.cnt = q.cnt - 12'h001;
    end
    case (q.pwr)
      PWR_NORMAL:
      begin
        if (exec)
        begin
          case (cmd)
            // deselect and no-op leave everything running
            CMD_DESEL, CMD_NOP:
            begin
              go = 1'b0;
            end
            // refresh holds the device for the row cycle
            CMD_REF:
            begin
              // refresh with an open bank is flagged
              if (all_idle)
              begin
                next_q.pwr = PWR_REFRESHING;
                next_q.cnt = 12'(RC_CYC);
                next_q.taken = 1'b1;
              end
              else
              begin
                next_q.illegal = 1'b1;
              end
            end
            // mode register set from all idle
            CMD_MRS:
            begin
              if (all_idle)
              begin
                next_q.pwr = PWR_MODE_REG;
                next_q.cnt = 12'(MRD_CYC);
                next_q.taken = 1'b1;
              end
              else
              begin
                next_q.illegal = 1'b1;
              end
            end
            // terminate with no burst started is flagged
            CMD_BST:
            begin
              go = q.last_valid;
              next_q.taken = q.last_valid;
              next_q.illegal = !q.last_valid;
              next_q.last_valid = 1'b0;
            end
            default:
            begin
              go = 1'b1;
              next_q.taken = 1'b1;
              if (cmd == CMD_RD || cmd == CMD_WR)
              begin
                next_q.last_bank = q.s2.ba;
                next_q.last_valid = !q.s2.a10;
              end
            end
          endcase
        end
        else if (q.cke_prev && !cke_now)
        begin
          // refresh code with enable low enters self refresh
          if (cmd == CMD_REF && all_idle)
          begin
            next_q.pwr = PWR_SELF_REF;
            next_q.bufs_on = 1'b0;
          end
          // terminate code with enable low, all idle
          else if (cmd == CMD_BST && all_idle)
          begin
            next_q.pwr = PWR_DEEP_PD;
            next_q.bufs_on = 1'b0;
          end
          // no entry while an access is in progress
          else if (!busy_access)
          begin
            // the variant follows the open rows
            next_q.pwr = all_idle ? PWR_PRE_PD : PWR_ACT_PD;
            next_q.bufs_on = 1'b0;
          end
        end
      end
      PWR_PRE_PD, PWR_ACT_PD:
      begin
        // exit needs enable high with no-op or deselect
        if (cke_now && (cmd == CMD_NOP || cmd == CMD_DESEL))
        begin
          next_q.pwr = PWR_NORMAL;
          next_q.bufs_on = 1'b1;
        end
      end
      PWR_SELF_REF:
      begin
        // hold off decode for the row cycle after exit
        if (cke_now)
        begin
          next_q.pwr = PWR_SREF_EXIT;
          next_q.cnt = 12'(SREX_CYC);
          next_q.bufs_on = 1'b1;
        end
      end
      PWR_DEEP_PD:
      begin
        // leave on enable high, then the init pause
        if (cke_now)
        begin
          next_q.pwr = PWR_INIT_WAIT;
          next_q.cnt = 12'(`SBSPM_INIT_PAUSE_CYC);
          next_q.bufs_on = 1'b1;
        end
      end
      PWR_SREF_EXIT, PWR_INIT_WAIT, PWR_REFRESHING, PWR_MODE_REG:
      begin
        // Commands here are ignored; the controller must send no-ops
        if (done)
        begin
          next_q.pwr = PWR_NORMAL;
        end
      end
      default:
      begin
        next_q.pwr = PWR_NORMAL;
        next_q.cnt = 12'h000;
        next_q.bufs_on = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Bank request fan-out
  // ****************************************************************
  always_comb
  begin
    for (int b = 0; b < `SBSPM_BANKS; b++)
    begin
      req[b].valid = go;
      req[b].cmd = cmd;
      req[b].ap = q.s2.a10;
      // address ten widens precharge to every bank
      req[b].sel = (q.s2.ba == 2'(b)) || (cmd == CMD_PRE && q.s2.a10);
      // terminate steered by the last burst bank
      req[b].bst_hit = q.last_valid && (q.last_bank == 2'(b));
      req[b].intr = (cmd == CMD_RD || cmd == CMD_WR) &&
                    (q.s2.ba != 2'(b));
      // banks see nothing while powered down except the wipe
      req[b].flush = (q.pwr == PWR_DEEP_PD);
    end
  end

  for (genvar g = 0; g < `SBSPM_BANKS; g++)
  begin : g_bank
    sbspm_bank #(
      .RCD_CYC(RCD_CYC),
      .RP_CYC(`SBSPM_PRECHARGE_CYC),
      .BURST_LEN(BURST_LEN)
    ) u_bank (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .req_i(req[g]),
      .state_o(bst[g])
    );
  end

  // State register
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '{s1: '0, s2: '0, cke_prev: 1'b0, pwr: PWR_NORMAL,
             cnt: 12'h000, last_bank: 2'h0, last_valid: 1'b0,
             taken: 1'b0, illegal: 1'b0, bufs_on: 1'b1};
    end
    else
    begin
      q <= next_q;
    end
  end

  assign bank_state_o = bst;
  assign pwr_mode_o = q.pwr;
  assign cmd_taken_o = q.taken;
  assign cmd_illegal_o = q.illegal;
  assign bufs_on_o = q.bufs_on;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic entry;
  assign entry = (q.pwr == PWR_NORMAL) && q.cke_prev && !cke_now;

  chk_refresh_len: assert property (
    exec && cmd == CMD_REF && all_idle |=>
    (q.pwr == PWR_REFRESHING)[*2] ##1 q.pwr == PWR_NORMAL)
    else $error("refresh window wrong length");

  chk_act_delay: assert property (
    exec && cmd == CMD_ACT && q.s2.ba == 2'h0 && bst[0] == BANK_IDLE |=>
    bst[0] == BANK_ACTIVATING ##1 bst[0] == BANK_ROW_ACTIVE)
    else $error("activation did not open row in time");

  chk_idle_precharge: assert property (
    exec && cmd == CMD_PRE && bst[2] == BANK_IDLE |=> bst[2] == BANK_IDLE)
    else $error("precharge disturbed idle bank");

  chk_pre_pd: assert property (
    entry && cmd == CMD_NOP && all_idle |=> q.pwr == PWR_PRE_PD && !bufs_on_o)
    else $error("precharge power-down not entered");

  chk_act_pd_rows: assert property (
    entry && cmd == CMD_NOP && !all_idle && !busy_access |=>
    q.pwr == PWR_ACT_PD && $stable(bst))
    else $error("active power-down lost rows");

  chk_pd_ignore: assert property (
    (q.pwr == PWR_PRE_PD || q.pwr == PWR_ACT_PD) && !cke_now |=>
    $stable(q.pwr) && $stable(bst) && !cmd_taken_o)
    else $error("pins acted on in power-down");

  chk_pd_exit: assert property (
    q.pwr == PWR_ACT_PD && cke_now && cmd == CMD_NOP |=>
    q.pwr == PWR_NORMAL && bufs_on_o)
    else $error("power-down exit late");

  chk_deep_entry: assert property (
    entry && cmd == CMD_BST && all_idle |=> q.pwr == PWR_DEEP_PD)
    else $error("deep power-down not entered");

  chk_deep_exit: assert property (
    q.pwr == PWR_DEEP_PD && cke_now |=>
    q.pwr == PWR_INIT_WAIT && q.cnt == 12'(`SBSPM_INIT_PAUSE_CYC))
    else $error("deep power-down exit wrong");

  chk_sref_exit: assert property (
    q.pwr == PWR_SELF_REF && cke_now |=>
    (q.pwr == PWR_SREF_EXIT)[*2] ##1 q.pwr == PWR_NORMAL)
    else $error("self refresh exit hold wrong");

  chk_burst_stop: assert property (
    exec && cmd == CMD_BST && q.last_valid && q.last_bank == 2'h1 &&
    bst[1] == BANK_WRITE |=> bst[1] == BANK_ROW_ACTIVE)
    else $error("terminate missed latest burst");

  chk_ref_busy: assert property (
    exec && cmd == CMD_REF && !all_idle |=>
    cmd_illegal_o && q.pwr == PWR_NORMAL)
    else $error("refresh with open bank not flagged");

  cov_self_ref: cover property (q.pwr == PWR_SELF_REF ##[1:50]
    q.pwr == PWR_NORMAL);
  cov_act_pd: cover property (q.pwr == PWR_ACT_PD);
  cov_read_ap: cover property (bst[0] == BANK_READ_AP ##[1:20]
    bst[0] == BANK_IDLE);
  cov_deep: cover property (q.pwr == PWR_INIT_WAIT);

endmodule

// *** dv/sbspm_ctrl_model.sv ***
`timescale 1ns/1ps
`include "sbspm_regs.svh"

// ****************************************************************
// Memory controller model driving the command pins
// ****************************************************************
module sbspm_ctrl_model
  import sbspm_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Command pins toward the device
  output sbspm_pins_t pins_o
);
  localparam int ROW_CYC = `SBSPM_ROW_CYCLE_CYC;

  // Idle bus with clock enable high until the first command
  initial
  begin
    pins_o = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0};
  end

  // Called at a falling edge; pins then hold for one full cycle
  task automatic send(input sbspm_pins_t p);
    pins_o = p;
    @(negedge ref_clk_i);
  endtask

  // row cycle gap
  // Whole cycles of no-op, so refresh and activate never crowd
  task automatic gap();
    sbspm_pins_t n;
    n = pins_o;
    n.cs_n = 1'b0;
    {n.ras_n, n.cas_n, n.we_n} = 3'h7;
    repeat (ROW_CYC + 1) send(n);
  endtask
endmodule

// *** dv/sbspm_bank_state_power_modes_tb.sv ***
`timescale 1ns/1ps

module sbspm_bank_state_power_modes_tb
  import sbspm_pkg::*;
;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_RD = 4'h5;
  localparam logic [3:0] C_WR = 4'h4;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_BST = 4'h6;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_MRS = 4'h0;
  logic ref_clk;
  logic rst_n;
  sbspm_pins_t pins;
  sbspm_bank_st_t [3:0] bank_st;
  sbspm_pwr_t pwr;
  logic taken;
  logic illegal;
  logic bufs_on;
  int mismatches = 0;
  int num_checks = 0;

  sbspm_ctrl_model i_ctrl (.ref_clk_i(ref_clk), .pins_o(pins));

  sbspm_top i_dut (
    .ref_clk_i(ref_clk),
    .rst_n_i(rst_n),
    .pins_i(pins),
    .bank_state_o(bank_st),
    .pwr_mode_o(pwr),
    .cmd_taken_o(taken),
    .cmd_illegal_o(illegal),
    .bufs_on_o(bufs_on)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic sbspm_pins_t mk(logic cke, logic [3:0] c, logic a10,
                                     logic [1:0] b);
    return '{cke, c[3], c[2], c[1], c[0], a10, b};
  endfunction

  // Power-down flavour follows whether any row is open
  function automatic sbspm_pwr_t pd_mode(logic any_open);
    return any_open ? PWR_ACT_PD : PWR_PRE_PD;
  endfunction

  task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic nop(int k, logic cke);
    repeat (k) i_ctrl.send(mk(cke, C_NOP, 1'b0, 2'h0));
  endtask

  // Command then no-ops; returns just after its outputs land
  task automatic op(sbspm_pins_t p);
    i_ctrl.send(p);
    nop(2, p.cke);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Deep power-down exit dominates the run time
  initial
  begin
    #(7000 * 50);
    mismatches++;
    wrap_up();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    int b;
    int s;
    int n;
    rst_n = 1'b0;
    void'($urandom(94061));
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    nop(3, 1'b1);
    for (b = 0; b < 4; b++)
    begin
      chk("reset bank", bank_st[b], BANK_IDLE);
    end
    chk("reset pwr", pwr, PWR_NORMAL);
    // activate each bank in turn, starting from a random bank
    s = $urandom % 4;
    for (b = 0; b < 4; b++)
    begin
      op(mk(1'b1, C_ACT, 1'b0, 2'((s + b) % 4)));
      chk("act taken", taken, 1'b1);
      chk("activating", bank_st[(s + b) % 4], BANK_ACTIVATING);
      nop(1, 1'b1);
      chk("row open", bank_st[(s + b) % 4], BANK_ROW_ACTIVE);
    end
    // Deselect with random strobes changes nothing
    op(mk(1'b1, {1'b1, 3'($urandom)}, 1'b0, 2'($urandom)));
    chk("desel taken", taken, 1'b0);
    chk("desel bank", bank_st[s], BANK_ROW_ACTIVE);
    // Burst terminate hits the later of two bursts
    i_ctrl.send(mk(1'b1, C_RD, 1'b0, 2'h0));
    i_ctrl.send(mk(1'b1, C_WR, 1'b0, 2'h1));
    i_ctrl.send(mk(1'b1, C_BST, 1'b0, 2'h2));
    nop(3, 1'b1);
    chk("read burst", bank_st[0], BANK_READ);
    chk("bst latest", bank_st[1], BANK_ROW_ACTIVE);
    // Precharge truncates a read burst
    // no busy bank addressed
    i_ctrl.send(mk(1'b1, C_RD, 1'b0, 2'h2));
    i_ctrl.send(mk(1'b1, C_PRE, 1'b0, 2'h2));
    nop(2, 1'b1);
    chk("pre trunc", bank_st[2], BANK_PRECHARGING);
    nop(1, 1'b1);
    chk("pre done", bank_st[2], BANK_IDLE);
    op(mk(1'b1, C_PRE, 1'b0, 2'h2));
    chk("pre idle", bank_st[2], BANK_IDLE);
    // Active power-down keeps rows and ignores pins
    // enable held low throughout
    op(mk(1'b0, C_NOP, 1'b0, 2'h0));
    chk("act pd", pwr, pd_mode(1'b1));
    chk("bufs off", bufs_on, 1'b0);
    op(mk(1'b0, C_RD, 1'b0, 2'h3));
    chk("pd ignore", bank_st[3], BANK_ROW_ACTIVE);
    chk("pd rows", bank_st[0], BANK_ROW_ACTIVE);
    op(mk(1'b1, C_NOP, 1'b0, 2'h0));
    chk("pd exit", pwr, PWR_NORMAL);
    chk("bufs on", bufs_on, 1'b1);
    nop(2, 1'b1);
    // refresh with an open row is refused
    op(mk(1'b1, C_REF, 1'b0, 2'h0));
    chk("ref illegal", illegal, 1'b1);
    op(mk(1'b1, C_RD, 1'b1, 2'h0));
    chk("read ap", bank_st[0], BANK_READ_AP);
    op(mk(1'b1, C_WR, 1'b0, 2'h3));
    chk("ap cut", bank_st[0], BANK_PRECHARGING);
    nop(1, 1'b1);
    chk("ap idle", bank_st[0], BANK_IDLE);
    // Precharge all, bank address ignored
    op(mk(1'b1, C_PRE, 1'b1, 2'($urandom)));
    chk("pre all", bank_st[1], BANK_PRECHARGING);
    nop(1, 1'b1);
    for (b = 0; b < 4; b++)
    begin
      chk("all idle", bank_st[b], BANK_IDLE);
    end
    op(mk(1'b0, C_NOP, 1'b0, 2'h0));
    chk("pre pd", pwr, pd_mode(1'b0));
    op(mk(1'b1, C_NOP, 1'b0, 2'h0));
    nop(2, 1'b1);
    // refresh and mode set run on no-ops only
    for (int i = 0; i < 2; i++)
    begin
      i_ctrl.gap();
      op(mk(1'b1, i ? C_MRS : C_REF, 1'b0, 2'h0));
      chk("global op", pwr, i ? PWR_MODE_REG : PWR_REFRESHING);
      nop(2, 1'b1);
      chk("global end", pwr, PWR_NORMAL);
    end
    // Self refresh entry and exit
    op(mk(1'b0, C_REF, 1'b0, 2'h0));
    chk("self ref", pwr, PWR_SELF_REF);
    op(mk(1'b1, C_NOP, 1'b0, 2'h0));
    chk("sref exit", pwr, PWR_SREF_EXIT);
    nop(2, 1'b1);
    chk("sref done", pwr, PWR_NORMAL);
    // Deep power-down then the full start-up pause
    op(mk(1'b0, C_BST, 1'b0, 2'h0));
    chk("deep pd", pwr, PWR_DEEP_PD);
    op(mk(1'b1, C_NOP, 1'b0, 2'h0));
    chk("init wait", pwr, PWR_INIT_WAIT);
    n = 0;
    while (pwr !== PWR_NORMAL && n < 5000)
    begin
      nop(1, 1'b1);
      n++;
    end
    chk("init pause", 4'(n > 3990 && n < 4010), 4'h1);
    wrap_up();
  end
endmodule
